// ===== verilog/serial_rom_consts.vh
`ifndef SERIAL_ROM_CONSTS_VH
`define SERIAL_ROM_CONSTS_VH

// register byte addresses
`define REG_COMMAND        8'hB0
`define REG_DATA           8'hB4
`define REG_STATION_LO     8'hB8
`define REG_STATION_HI     8'hBC

// command register fields
`define CMD_BUSY_BIT       31
`define CMD_OP_HI          30
`define CMD_OP_LO          28
`define CMD_TIMEOUT_BIT    9
`define CMD_ADDR_HI        6
`define CMD_ADDR_LO        0

// command field encodings
`define OP_READ            3'h0
`define OP_EWDS            3'h1
`define OP_EWEN            3'h2
`define OP_WRITE           3'h3
`define OP_WRITE_ALL       3'h4
`define OP_ERASE           3'h5
`define OP_ERASE_ALL       3'h6
`define OP_RELOAD          3'h7

// reset values
`define RST_OP             3'h0
`define RST_ADDR           7'h00
`define RST_DATA           8'h00
`define RST_STATION        48'h000000000000

// station address occupies serial rom bytes 0..5
`define STATION_LAST_IDX   3'h5

// frame lengths in serial clock periods
`define FRAME_SHORT        5'h0A
`define FRAME_LONG         5'h12

// timing, clock 25 MHz
`define CLK_MHZ            25
`define SCK_HALF_NS        500
`define SCK_HALF_CYC       ((`SCK_HALF_NS * `CLK_MHZ + 999) / 1000)
`define NODEV_TIMEOUT_US   30000
// 30 ms at 25 MHz, sized to the 20-bit poll counter
`define NODEV_TIMEOUT_CYC  20'hB71B0
`define POLL_SETTLE_CYC    20'h00004

// axi responses
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== verilog/serial_rom_shifter.v
`timescale 1ns/1ns
`include "serial_rom_consts.vh"

module serial_rom_shifter #(
   parameter [19:0] TIMEOUT_CYCLES = `NODEV_TIMEOUT_CYC
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire        start,
   input  wire        poll,
   input  wire [4:0]  nbits,
   input  wire [17:0] tx,
   output reg         done,
   output reg         timed_out,
   output reg  [7:0]  rx,
   output reg         rom_cs,
   output reg         rom_sck,
   output reg         rom_di,
   input  wire        rom_do
);

localparam [1:0] P_IDLE  = 2'h0;
localparam [1:0] P_SHIFT = 2'h1;
localparam [1:0] P_POLL  = 2'h2;
localparam [1:0] P_GAP   = 2'h3;
localparam integer HALF_INT = `SCK_HALF_CYC;
localparam [7:0]   HALF     = HALF_INT[7:0];

reg  [1:0]  st_q;
reg  [7:0]  div_q;
reg  [4:0]  cnt_q;
reg  [17:0] sh_q;
reg  [19:0] tcnt_q;
reg         do_meta_q;
reg         do_sync_q;
wire        tick;

assign tick = (div_q == HALF - 8'h01);

//////////////////////////////////////////////////////////////////////////
// serial clock rate is a one-cycle enable from a free divider
always @(posedge aclk) begin
   if (!aresetn || tick) begin
      div_q <= 8'h00;
   end else begin
      div_q <= div_q + 8'h01;
   end
end

always @(posedge aclk) begin
   if (!aresetn) begin
      do_meta_q <= 1'b0;
      do_sync_q <= 1'b0;
   end else begin
      do_meta_q <= rom_do;
      do_sync_q <= do_meta_q;
   end
end

//////////////////////////////////////////////////////////////////////////
always @(posedge aclk) begin
   if (!aresetn) begin
      st_q      <= P_IDLE;
      cnt_q     <= 5'h00;
      sh_q      <= 18'h00000;
      tcnt_q    <= 20'h00000;
      done      <= 1'b0;
      timed_out <= 1'b0;
      rx        <= 8'h00;
      rom_cs    <= 1'b0;
      rom_sck   <= 1'b0;
      rom_di    <= 1'b0;
   end else begin
      done <= 1'b0;
      case (st_q)
         P_IDLE: begin
            if (start && poll) begin
               rom_cs    <= 1'b1;
               tcnt_q    <= 20'h00000;
               timed_out <= 1'b0;
               st_q      <= P_POLL;
            end else if (start) begin
               rom_cs  <= 1'b1;
               rom_di  <= tx[17];
               sh_q    <= {tx[16:0], 1'b0};
               cnt_q   <= nbits;
               rom_sck <= 1'b0;
               st_q    <= P_SHIFT;
            end
         end
         P_SHIFT: begin
            if (tick) begin
               if (!rom_sck) begin
                  rom_sck <= 1'b1;
                  rx      <= {rx[6:0], do_sync_q};
                  cnt_q   <= cnt_q - 5'h01;
               end else begin
                  rom_sck <= 1'b0;
                  if (cnt_q == 5'h00) begin
                     rom_cs <= 1'b0;
                     rom_di <= 1'b0;
                     st_q   <= P_GAP;
                  end else begin
                     rom_di <= sh_q[17];
                     sh_q   <= {sh_q[16:0], 1'b0};
                  end
               end
            end
         end
         P_POLL: begin
            // a floating data line may read high at once; let it settle
            tcnt_q <= tcnt_q + 20'h00001;
            if (do_sync_q && tcnt_q >= `POLL_SETTLE_CYC) begin
               rom_cs <= 1'b0;
               st_q   <= P_GAP;
            end else if (tcnt_q == TIMEOUT_CYCLES - 20'h00001) begin
               timed_out <= 1'b1;
               rom_cs    <= 1'b0;
               st_q      <= P_GAP;
            end
         end
         P_GAP: begin
            // chip select stays low until the next tick: a full half period after a shifted frame, as little as one cycle after a poll
            if (tick) begin
               done <= 1'b1;
               st_q <= P_IDLE;
            end
         end
         default: begin
            st_q <= P_IDLE;
         end
      endcase
   end
end

endmodule // serial_rom_shifter

// ===== verilog/serial_rom_command_engine.v
`timescale 1ns/1ns
`include "serial_rom_consts.vh"

module serial_rom_command_engine #(
   parameter [19:0] TIMEOUT_CYCLES = `NODEV_TIMEOUT_CYC
) (
   input  wire        aclk,
   input  wire        aresetn,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   output wire        rom_cs,
   output wire        rom_sck,
   output wire        rom_di,
   input  wire        rom_do
);

localparam [1:0] S_IDLE  = 2'h0;
localparam [1:0] S_KICK  = 2'h1;
localparam [1:0] S_FRAME = 2'h2;
localparam [1:0] S_POLL  = 2'h3;

reg  [1:0]  st_q;
reg         op_in_progress_flag_q;
reg  [2:0]  op_q;
reg  [6:0]  addr_q;
reg         timeout_q;
reg  [7:0]  data_q;
reg  [47:0] station_q;
reg         loading_q;
reg  [2:0]  idx_q;
reg         start_q;
reg         poll_q;
reg  [4:0]  nbits_q;
reg  [17:0] tx_q;
reg  [7:0]  awaddr_q;
reg         aw_full_q;
reg  [31:0] wdata_q;
reg  [3:0]  wstrb_q;
reg         w_full_q;

wire        wr_fire;
wire        sh_done;
wire        sh_timed_out;
wire [7:0]  sh_rx;
wire [31:0] cur_word;
wire [31:0] wmerge;
wire [2:0]  frame_op;
wire [6:0]  frame_addr;
reg  [17:0] frame_tx;
reg  [4:0]  frame_n;
reg         frame_poll;

function [31:0] reg_value;
   input [7:0] a;
   begin
      case (a)
         `REG_COMMAND:    reg_value = {op_in_progress_flag_q, op_q, 18'h00000,
                                       timeout_q, 2'h0, addr_q};
         `REG_DATA:       reg_value = {24'h000000, data_q};
         `REG_STATION_LO: reg_value = station_q[31:0];
         `REG_STATION_HI: reg_value = {16'h0000, station_q[47:32]};
         default:         reg_value = 32'h00000000;
      endcase
   end
endfunction

function mapped;
   input [7:0] a;
   begin
      mapped = (a == `REG_COMMAND) || (a == `REG_DATA) ||
               (a == `REG_STATION_LO) || (a == `REG_STATION_HI);
   end
endfunction

//////////////////////////////////////////////////////////////////////////
// axi4-lite slave: one write and one read outstanding
assign wr_fire  = aw_full_q && w_full_q && !s_axi_bvalid;
// only command and data take writes; spelled out so it follows the registers
assign cur_word = (awaddr_q == `REG_DATA) ? {24'h000000, data_q} :
                  {op_in_progress_flag_q, op_q, 18'h00000, timeout_q,
                   2'h0, addr_q};

genvar g;
generate
   for (g = 0; g < 4; g = g + 1) begin : g_lane
      assign wmerge[g*8 +: 8] = wstrb_q[g] ? wdata_q[g*8 +: 8]
                                           : cur_word[g*8 +: 8];
   end
endgenerate

always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_full_q     <= 1'b0;
      w_full_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h00000000;
      wstrb_q       <= 4'h0;
   end else begin
      if (s_axi_awvalid && s_axi_awready) begin
         awaddr_q      <= s_axi_awaddr;
         aw_full_q     <= 1'b1;
         s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
         w_full_q     <= 1'b1;
         s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
         aw_full_q    <= 1'b0;
         w_full_q     <= 1'b0;
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(awaddr_q) ? `RESP_OKAY : `RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
         s_axi_bvalid  <= 1'b0;
         s_axi_awready <= 1'b1;
         s_axi_wready  <= 1'b1;
      end
   end
end

always @(posedge aclk) begin
   if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h00000000;
      s_axi_rresp   <= `RESP_OKAY;
   end else begin
      if (s_axi_arvalid && s_axi_arready) begin
         s_axi_rdata   <= reg_value(s_axi_araddr);
         s_axi_rresp   <= mapped(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
         s_axi_rvalid  <= 1'b1;
         s_axi_arready <= 1'b0;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end
end

//////////////////////////////////////////////////////////////////////////
// frame builder: start bit, opcode, address, then data where needed
assign frame_op   = loading_q ? `OP_READ : op_q;
assign frame_addr = loading_q ? {4'h0, idx_q} : addr_q;

always @* begin
   frame_tx   = 18'h00000;
   frame_n    = `FRAME_SHORT;
   frame_poll = 1'b0;
   case (frame_op)
      `OP_READ: begin
         frame_tx = {3'b110, frame_addr, 8'h00};
         frame_n  = `FRAME_LONG;
      end
      `OP_EWDS: begin
         frame_tx = {3'b100, 2'b00, 5'h00, 8'h00};
      end
      `OP_EWEN: begin
         frame_tx = {3'b100, 2'b11, 5'h00, 8'h00};
      end
      `OP_WRITE: begin
         frame_tx   = {3'b101, frame_addr, data_q};
         frame_n    = `FRAME_LONG;
         frame_poll = 1'b1;
      end
      `OP_WRITE_ALL: begin
         frame_tx   = {3'b100, 2'b01, 5'h00, data_q};
         frame_n    = `FRAME_LONG;
         frame_poll = 1'b1;
      end
      `OP_ERASE: begin
         frame_tx   = {3'b111, frame_addr, 8'h00};
         frame_poll = 1'b1;
      end
      `OP_ERASE_ALL: begin
         frame_tx   = {3'b100, 2'b10, 5'h00, 8'h00};
         frame_poll = 1'b1;
      end
      default: begin
         frame_tx = 18'h00000;
      end
   endcase
end

//////////////////////////////////////////////////////////////////////////
// command sequencer
always @(posedge aclk) begin
   if (!aresetn) begin
      st_q                  <= S_KICK;
      op_in_progress_flag_q <= 1'b1;
      loading_q             <= 1'b1;
      idx_q                 <= 3'h0;
      op_q                  <= `RST_OP;
      addr_q                <= `RST_ADDR;
      data_q                <= `RST_DATA;
      station_q             <= `RST_STATION;
      timeout_q             <= 1'b0;
      start_q               <= 1'b0;
      poll_q                <= 1'b0;
      nbits_q               <= 5'h00;
      tx_q                  <= 18'h00000;
   end else begin
      start_q <= 1'b0;
      // writes are ignored while an operation runs
      if (wr_fire && !op_in_progress_flag_q) begin
         if (awaddr_q == `REG_DATA) begin
            data_q <= wmerge[7:0];
         end
         if (awaddr_q == `REG_COMMAND) begin
            op_q   <= wmerge[`CMD_OP_HI:`CMD_OP_LO];
            addr_q <= wmerge[`CMD_ADDR_HI:`CMD_ADDR_LO];
            if (wmerge[`CMD_BUSY_BIT]) begin
               op_in_progress_flag_q <= 1'b1;
               timeout_q             <= 1'b0;
               st_q                  <= S_KICK;
               if (wmerge[`CMD_OP_HI:`CMD_OP_LO] == `OP_RELOAD) begin
                  loading_q <= 1'b1;
                  idx_q     <= 3'h0;
               end
            end
         end
      end
      case (st_q)
         S_IDLE: begin
         end
         S_KICK: begin
            start_q <= 1'b1;
            poll_q  <= 1'b0;
            tx_q    <= frame_tx;
            nbits_q <= frame_n;
            st_q    <= S_FRAME;
         end
         S_FRAME: begin
            if (sh_done) begin
               if (frame_op == `OP_READ) begin
                  if (loading_q) begin
                     station_q[idx_q*8 +: 8] <= sh_rx;
                  end else begin
                     data_q <= sh_rx;
                  end
               end
               if (loading_q && idx_q != `STATION_LAST_IDX) begin
                  idx_q <= idx_q + 3'h1;
                  st_q  <= S_KICK;
               end else if (frame_poll) begin
                  start_q <= 1'b1;
                  poll_q  <= 1'b1;
                  st_q    <= S_POLL;
               end else begin
                  loading_q             <= 1'b0;
                  op_in_progress_flag_q <= 1'b0;
                  st_q                  <= S_IDLE;
               end
            end
         end
         S_POLL: begin
            if (sh_done) begin
               timeout_q             <= sh_timed_out;
               op_in_progress_flag_q <= 1'b0;
               st_q                  <= S_IDLE;
            end
         end
         default: begin
            st_q <= S_IDLE;
         end
      endcase
   end
end

serial_rom_shifter #(
   .TIMEOUT_CYCLES (TIMEOUT_CYCLES)
) u_shifter (
   .aclk      (aclk),
   .aresetn   (aresetn),
   .start     (start_q),
   .poll      (poll_q),
   .nbits     (nbits_q),
   .tx        (tx_q),
   .done      (sh_done),
   .timed_out (sh_timed_out),
   .rx        (sh_rx),
   .rom_cs    (rom_cs),
   .rom_sck   (rom_sck),
   .rom_di    (rom_di),
   .rom_do    (rom_do)
);

endmodule // serial_rom_command_engine

// ===== testbench/serial_rom_command_engine_monitor.sv
`timescale 1ns/1ns
module serial_rom_command_engine_monitor #(
   parameter [19:0] TIMEOUT_CYCLES = 20'h000C8
) (
   input wire        aclk,
   input wire        aresetn,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire        s_axi_bvalid,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire [31:0] s_axi_rdata,
   input wire        rom_cs,
   input wire        rom_sck,
   input wire        rom_di
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // a select held past the limit means the poll never gives up
   reg [19:0] cs_run_q;
   always @(posedge aclk) begin
      if (!aresetn || !rom_cs) begin
         cs_run_q <= 20'h00000;
      end else begin
         cs_run_q <= cs_run_q + 20'h00001;
      end
   end
   //////////////////////////////////////////////
   chk_reset_pins: assert property (disable iff (1'b0)
      !aresetn |=> !rom_cs && !rom_sck) else $error("rom pins in reset");
   chk_boot_read: assert property ($rose(aresetn) |-> ##[1:40] rom_cs)
      else $error("no boot frame");
   chk_write_lat: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
      else $error("late write response");
   chk_read_lat: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("late read response");
   chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
   chk_di_stable: assert property (rom_sck && $past(rom_sck) |->
      $stable(rom_di)) else $error("di moved while sck high");
   chk_sck_gated: assert property (!rom_cs |-> !rom_sck)
      else $error("sck without select");
   chk_cs_bound: assert property (cs_run_q < TIMEOUT_CYCLES + 20'h00258)
      else $error("select held too long");
endmodule // serial_rom_command_engine_monitor

bind serial_rom_command_engine serial_rom_command_engine_monitor #(
   .TIMEOUT_CYCLES(TIMEOUT_CYCLES)
) u_monitor (
   .aclk(aclk), .aresetn(aresetn),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
   .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
   .rom_cs(rom_cs), .rom_sck(rom_sck), .rom_di(rom_di)
);

// ===== testbench/serial_rom_model.sv
`timescale 1ns/1ns
module serial_rom_model (
   input  wire aclk,
   input  wire rom_cs,
   input  wire rom_sck,
   input  wire rom_di,
   input  wire absent,
   input  wire slow,
   output wire rom_do
);
   reg  [7:0]  mem [0:127];
   reg  [17:0] sh;
   reg  [4:0]  n;
   reg  [7:0]  rbuf, wait_q;
   reg         sck_q, ew, rding, pend, do_q;
   integer     i;
   wire [17:0] w = {sh[16:0], rom_di};
   // weak pull-down: an absent or idle part reads as 0
   assign rom_do = do_q & ~absent;
   initial begin
      for (i = 0; i < 128; i = i + 1) mem[i] = i * 37 + 91;
      {sh, n, rbuf, wait_q, sck_q, ew, rding, pend, do_q} = 0;
   end
   always @(posedge aclk) begin
      sck_q <= rom_sck;
      if (wait_q != 8'h00) wait_q <= wait_q - 8'h01;
      if (!rom_cs || absent) begin
         n <= 5'h00;
         rding <= 1'b0;
         do_q <= 1'b0;
      end else if (rom_sck && !sck_q) begin
         sh <= w;
         n <= n + 5'h01;
         pend <= 1'b0;
         // slow parts stay busy into the poll but stay inside the engine limit
         if (n == 5'h09 || n == 5'h11) wait_q <= slow ? 8'h96 : 8'h0C;
         if (n == 5'h09) begin
            case (w[8:7])
               2'b10: begin
                  rbuf <= mem[w[6:0]];
                  rding <= 1'b1;
               end
               2'b11: if (ew) begin
                  mem[w[6:0]] <= 8'hFF;
                  pend <= 1'b1;
               end
               2'b00: begin
                  if (w[6:5] == 2'b11) ew <= 1'b1;
                  if (w[6:5] == 2'b00) ew <= 1'b0;
                  if (w[6:5] == 2'b10 && ew) begin
                     for (i = 0; i < 128; i = i + 1) mem[i] <= 8'hFF;
                     pend <= 1'b1;
                  end
               end
               default: ;
            endcase
         end
         if (n == 5'h11 && ew) begin
            if (w[16:15] == 2'b01) mem[w[14:8]] <= w[7:0];
            if (w[16:13] == 4'b0001) begin
               for (i = 0; i < 128; i = i + 1) mem[i] <= w[7:0];
            end
            pend <= w[16:15] == 2'b01 || w[16:13] == 4'b0001;
         end
      end else if (!rom_sck && sck_q && rding) begin
         do_q <= rbuf[7];
         rbuf <= {rbuf[6:0], 1'b0};
      end else if (!rding) begin
         do_q <= pend && n == 5'h00 && wait_q == 8'h00;
      end
   end
endmodule // serial_rom_model

// ===== testbench/serial_rom_command_engine_tb.sv
`timescale 1ns/1ns
module serial_rom_command_engine_tb;
   localparam [19:0] TO = 20'h000C8;
   reg         aclk, aresetn, awv, wv, bry, arv, rry, absent, slow;
   reg  [7:0]  awa, ara, a, d, e;
   reg  [31:0] wd, v;
   reg  [1:0]  resp;
   wire        awr, wrdy, bv, arr, rv, cs, sck, di, dout;
   wire [1:0]  br, rr;
   wire [31:0] rd;
   integer     error_cnt, total_checks, seed, i, j, k, t0;
   always #20 aclk = ~aclk;
   serial_rom_command_engine #(.TIMEOUT_CYCLES(TO)) DUT (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
      .s_axi_wready(wrdy), .s_axi_bresp(br), .s_axi_bvalid(bv),
      .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
      .s_axi_rvalid(rv), .s_axi_rready(rry), .rom_cs(cs),
      .rom_sck(sck), .rom_di(di), .rom_do(dout));
   serial_rom_model u_rom (.aclk(aclk), .rom_cs(cs), .rom_sck(sck),
      .rom_di(di), .absent(absent), .slow(slow), .rom_do(dout));
   //////////////////////////////////////////////
   function [7:0] ib(input integer x);
      ib = x[7:0] * 8'h25 + 8'h5B;
   endfunction
   task check(input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   task axi_wr(input [7:0] ad, input [31:0] dat);
      begin
         @(posedge aclk);
         awa <= ad;
         wd <= dat;
         awv <= 1'b1;
         wv <= 1'b1;
         bry <= 1'b1;
         do begin
            @(posedge aclk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
         end while (bv !== 1'b1);
         resp = br;
         bry <= 1'b0;
      end
   endtask
   task axi_rd(input [7:0] ad, output [31:0] dat);
      begin
         @(posedge aclk);
         ara <= ad;
         arv <= 1'b1;
         rry <= 1'b1;
         do begin
            @(posedge aclk);
            if (arr) arv <= 1'b0;
         end while (rv !== 1'b1);
         dat = rd;
         resp = rr;
         rry <= 1'b0;
      end
   endtask
   // nothing is written while busy, so polling is the only traffic
   task poll;
      begin
         axi_rd(8'hB0, v);
         check(v >> 31, 32'h1);
         for (k = 0; k < 5000 && v[31] !== 1'b0; k = k + 1) begin
            axi_rd(8'hB0, v);
         end
         check({31'h0, v[31]}, 32'h0);
      end
   endtask
   task cmd(input [2:0] op, input [6:0] ad);
      begin
         v = $random(seed);
         slow <= v[0];
         axi_wr(8'hB0, {1'b1, op, 21'h000000, ad});
         poll;
      end
   endtask
   task final_report;
      begin
         $display("checks %0d mismatches %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0) begin
            $display("All checks passed");
         end else begin
            $display("Checks failed");
         end
         $finish;
      end
   endtask
   //////////////////////////////////////////////
   initial begin
      aclk = 1'b0;
      {aresetn, awv, wv, bry, arv, rry, absent, slow} = 8'h00;
      {awa, ara, wd} = 48'h000000000000;
      error_cnt = 0;
      total_checks = 0;
      seed = 63462;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      poll;
      axi_rd(8'hB8, v);
      check(v, {ib(3), ib(2), ib(1), ib(0)});
      axi_rd(8'hBC, v);
      check(v, {16'h0000, ib(5), ib(4)});
      axi_rd(8'hC0, v);
      check({30'h0, resp}, 32'h2);
      $display("boot test done");
      cmd(3'h2, 7'h00);
      for (i = 0; i < 6; i = i + 1) begin
         v = $random(seed);
         a = (i == 0) ? 8'h7F : {1'b0, v[6:0]};
         d = v[15:8];
         axi_wr(8'hB4, {24'h000000, d});
         cmd(3'h3, a[6:0]);
         check({24'h0, u_rom.mem[a[6:0]]}, {24'h0, d});
         axi_wr(8'hB4, 32'h00000000);
         cmd(3'h0, a[6:0]);
         axi_rd(8'hB4, v);
         check(v, {24'h000000, d});
      end
      $display("write read test done");
      e = u_rom.mem[a[6:0] ^ 7'h01];
      cmd(3'h5, a[6:0]);
      check({24'h0, u_rom.mem[a[6:0]]}, 32'hFF);
      check({24'h0, u_rom.mem[a[6:0] ^ 7'h01]}, {24'h0, e});
      v = $random(seed);
      d = v[7:0];
      axi_wr(8'hB4, {24'h000000, d});
      cmd(3'h4, 7'h00);
      for (j = 0; j < 128; j = j + 1) begin
         check({24'h0, u_rom.mem[j]}, {24'h0, d});
      end
      cmd(3'h6, 7'h00);
      for (j = 0; j < 128; j = j + 1) begin
         check({24'h0, u_rom.mem[j]}, 32'hFF);
      end
      cmd(3'h1, 7'h00);
      // data other than the erased value, so a refused write is visible
      axi_wr(8'hB4, 32'h0000005A);
      cmd(3'h3, a[6:0]);
      check({24'h0, u_rom.mem[a[6:0]]}, 32'hFF);
      cmd(3'h7, 7'h00);
      axi_rd(8'hB8, v);
      check(v, 32'hFFFFFFFF);
      axi_rd(8'hBC, v);
      check(v, 32'h0000FFFF);
      $display("bulk test done");
      absent <= 1'b1;
      t0 = $time;
      cmd(3'h3, 7'h05);
      check(v & 32'h80000200, 32'h200);
      // 18 rom clocks of 26 cycles go out before the poll starts
      check({31'h0, ($time - t0) >= (TO + 468) * 40}, 32'h1);
      $display("no device test done");
      final_report;
   end
   initial begin
      #4000000;
      error_cnt = error_cnt + 1;
      final_report;
   end
endmodule // serial_rom_command_engine_tb
